// *** mme_cfg.svh ***
`ifndef MME_CFG_SVH
`define MME_CFG_SVH
`define MME_ADDR_W 32
`define MME_COPY_SEL_BIT 15
`define MME_CHUNK_W 64
`define MME_NUM_SLOTS 4
`define MME_CNT_W 8
`define MME_LEAK_W 16
`define MME_POL_RST 1'b0
`define MME_LEAK_RST 16'h0100
`endif

// *** mme_pkg.sv ***
package mme_pkg;
	typedef enum logic [2:0] {
		MME_IDLE = 3'b000,
		MME_WR_PRI = 3'b001,
		MME_WR_MIR = 3'b011,
		MME_RD_WAIT = 3'b010,
		MME_RD_RETRY = 3'b110
	} mme_state_t;
	typedef enum logic [1:0] {
		MME_FEAT_NONE = 2'b00,
		MME_FEAT_MIRROR = 2'b01,
		MME_FEAT_SPARE = 2'b10
	} mme_feat_t;
endpackage

// *** mme_leaky_bucket.sv ***
`timescale 1ns/1ps
`include "mme_cfg.svh"
module mme_leaky_bucket
	import mme_pkg::*;
(
	input wire logic clk_in,
	input wire logic srst_in,
	input wire logic ce_in,
	input wire logic err_in,
	input wire logic [`MME_LEAK_W-1:0] leak_period_in,
	output logic [`MME_CNT_W-1:0] count_out
);
	logic [`MME_LEAK_W-1:0] leak_cnt;
	logic leak_tick;
	assign leak_tick = (leak_period_in != '0) && (leak_cnt >= leak_period_in - 1'b1);
	always_ff @(posedge clk_in)
	begin
		if (srst_in)
			leak_cnt <= '0;
		else if (ce_in)
			leak_cnt <= leak_tick ? '0 : leak_cnt + 1'b1;
	end
	// an error in the leak cycle still counts: net change is zero
	always_ff @(posedge clk_in)
	begin
		if (srst_in)
			count_out <= '0;
		else if (ce_in)
		begin
			if (err_in && !leak_tick && count_out != '1)
				count_out <= count_out + 1'b1;
			else if (!err_in && leak_tick && count_out != '0)
				count_out <= count_out - 1'b1;
		end
	end
	bucket_no_wrap_a: assert property (@(posedge clk_in) disable iff (srst_in)
		$past(count_out) == '1 |-> count_out != '0)
		else $error("bucket wrapped");
endmodule // mme_leaky_bucket

// *** mme_mirror_engine.sv ***
`timescale 1ns/1ps
`include "mme_cfg.svh"
module mme_mirror_engine
	import mme_pkg::*;
(
	input wire logic clk_in,
	input wire logic srst_in,
	input wire logic ce_in,
	input wire logic mirror_en_in,
	input wire logic spare_en_in,
	input wire logic polarity_in,
	input wire logic polarity_we_in,
	input wire logic [`MME_LEAK_W-1:0] leak_period_in,
	input wire logic interleave_in,
	input wire logic req_valid_in,
	input wire logic req_write_in,
	input wire logic [`MME_ADDR_W-1:0] req_addr_in,
	input wire logic [1:0] req_slot_in,
	input wire logic [`MME_CHUNK_W-1:0] req_even_in,
	input wire logic [`MME_CHUNK_W-1:0] req_odd_in,
	input wire logic mem_ack_in,
	input wire logic [`MME_CHUNK_W-1:0] mem_cha_in,
	input wire logic [`MME_CHUNK_W-1:0] mem_chb_in,
	input wire logic mem_ce_in,
	input wire logic mem_ue_in,
	output logic req_ready_out,
	output logic mem_valid_out,
	output logic mem_write_out,
	output logic mem_mirror_out,
	output logic [`MME_ADDR_W-1:0] mem_addr_out,
	output logic [`MME_CHUNK_W-1:0] mem_cha_out,
	output logic [`MME_CHUNK_W-1:0] mem_chb_out,
	output logic rsp_valid_out,
	output logic [`MME_CHUNK_W-1:0] rsp_even_out,
	output logic [`MME_CHUNK_W-1:0] rsp_odd_out,
	output logic rsp_fatal_out,
	output logic ce_event_out,
	output logic ue_event_out,
	output logic mirror_active_out,
	output logic [`MME_NUM_SLOTS*`MME_CNT_W-1:0] bucket_out
);
	mme_state_t state;
	mme_feat_t feat;
	logic polarity;
	logic [`MME_CHUNK_W-1:0] even_q;
	logic [`MME_CHUNK_W-1:0] odd_q;
	logic [1:0] slot_q;
	logic cur_mirror;
	logic [`MME_NUM_SLOTS-1:0] slot_err;
	logic [`MME_NUM_SLOTS*`MME_CNT_W-1:0] bucket;
	logic mirrored;

	// which copy a read targets first
	function automatic logic pick_mirror(input logic [`MME_ADDR_W-1:0] a, input logic pol);
		pick_mirror = a[`MME_COPY_SEL_BIT] ^ pol;
	endfunction

	assign mirrored = (feat == MME_FEAT_MIRROR);

	// feature latches once; no backing out without a full reset
	always_ff @(posedge clk_in)
	begin
		if (srst_in)
			feat <= MME_FEAT_NONE;
		else if (ce_in && feat == MME_FEAT_NONE)
		begin
			if (mirror_en_in && !spare_en_in)
				feat <= MME_FEAT_MIRROR;
			else if (spare_en_in && !mirror_en_in)
				feat <= MME_FEAT_SPARE;
		end
	end

	always_ff @(posedge clk_in)
	begin
		if (srst_in)
			polarity <= `MME_POL_RST;
		else if (ce_in && polarity_we_in)
			polarity <= polarity_in;
	end

	always_ff @(posedge clk_in)
	begin
		if (srst_in)
		begin
			state <= MME_IDLE;
			req_ready_out <= 1'b0;
			mem_valid_out <= 1'b0;
			mem_write_out <= 1'b0;
			mem_mirror_out <= 1'b0;
			mem_addr_out <= '0;
			mem_cha_out <= '0;
			mem_chb_out <= '0;
			rsp_valid_out <= 1'b0;
			rsp_even_out <= '0;
			rsp_odd_out <= '0;
			rsp_fatal_out <= 1'b0;
			even_q <= '0;
			odd_q <= '0;
			slot_q <= '0;
			cur_mirror <= 1'b0;
		end
		else if (ce_in)
		begin
			rsp_valid_out <= 1'b0;
			rsp_fatal_out <= 1'b0;
			unique case (state)
				MME_IDLE:
				begin
					req_ready_out <= 1'b1;
					if (req_valid_in && req_ready_out)
					begin
						req_ready_out <= 1'b0;
						mem_valid_out <= 1'b1;
						mem_write_out <= req_write_in;
						mem_addr_out <= req_addr_in;
						mem_cha_out <= req_even_in;
						mem_chb_out <= req_odd_in;
						even_q <= req_even_in;
						odd_q <= req_odd_in;
						slot_q <= req_slot_in;
						if (req_write_in)
						begin
							mem_mirror_out <= 1'b0;
							state <= MME_WR_PRI;
						end
						else
						begin
							cur_mirror <= mirrored && pick_mirror(req_addr_in, polarity);
							mem_mirror_out <= mirrored && pick_mirror(req_addr_in, polarity);
							state <= MME_RD_WAIT;
						end
					end
				end
				MME_WR_PRI:
					if (mem_ack_in)
					begin
						if (mirrored)
						begin
							// swapped lanes leave a whole copy on each channel
							mem_mirror_out <= 1'b1;
							mem_cha_out <= odd_q;
							mem_chb_out <= even_q;
							state <= MME_WR_MIR;
						end
						else
						begin
							mem_valid_out <= 1'b0;
							state <= MME_IDLE;
						end
					end
				MME_WR_MIR:
					if (mem_ack_in)
					begin
						mem_valid_out <= 1'b0;
						state <= MME_IDLE;
					end
				MME_RD_WAIT, MME_RD_RETRY:
					if (mem_ack_in)
					begin
						if (mem_ue_in && mirrored && state == MME_RD_WAIT)
						begin
							cur_mirror <= !cur_mirror;
							mem_mirror_out <= !cur_mirror;
							state <= MME_RD_RETRY;
						end
						else
						begin
							// even chunk lane follows copy and interleave mode
							if (interleave_in ? cur_mirror : 1'b0)
							begin
								rsp_even_out <= mem_chb_in;
								rsp_odd_out <= mem_cha_in;
							end
							else
							begin
								rsp_even_out <= mem_cha_in;
								rsp_odd_out <= mem_chb_in;
							end
							rsp_valid_out <= 1'b1;
							rsp_fatal_out <= mem_ue_in;
							mem_valid_out <= 1'b0;
							state <= MME_IDLE;
						end
					end
				default:
					state <= MME_IDLE;
			endcase
		end
	end

	// errors are charged to the slot of the copy that returned them
	always_ff @(posedge clk_in)
	begin
		if (srst_in)
		begin
			ce_event_out <= 1'b0;
			ue_event_out <= 1'b0;
			mirror_active_out <= 1'b0;
			bucket_out <= '0;
		end
		else if (ce_in)
		begin
			ce_event_out <= mem_ack_in && mem_ce_in && !mem_write_out;
			ue_event_out <= mem_ack_in && mem_ue_in && !mem_write_out;
			mirror_active_out <= mirrored;
			bucket_out <= bucket;
		end
	end

	genvar gi;
	generate
		for (gi = 0; gi < `MME_NUM_SLOTS; gi = gi + 1)
		begin : g_bucket
			assign slot_err[gi] = mem_valid_out && !mem_write_out && mem_ack_in
				&& (mem_ce_in || mem_ue_in)
				&& ({slot_q[1], slot_q[0] ^ cur_mirror} == 2'(gi));
			mme_leaky_bucket u_bucket (
				.clk_in(clk_in),
				.srst_in(srst_in),
				.ce_in(ce_in),
				.err_in(slot_err[gi]),
				.leak_period_in(leak_period_in),
				.count_out(bucket[gi*`MME_CNT_W +: `MME_CNT_W])
			);
		end
	endgenerate

	mirror_write_twice_a: assert property (@(posedge clk_in) disable iff (srst_in || !ce_in)
		state == MME_WR_PRI && mem_ack_in && mirrored |=> state == MME_WR_MIR && mem_mirror_out)
		else $error("no mirror write");
	lane_swap_a: assert property (@(posedge clk_in) disable iff (srst_in || !ce_in)
		state == MME_WR_MIR |-> mem_cha_out == odd_q && mem_chb_out == even_q)
		else $error("mirror lanes not swapped");
	unmirrored_single_a: assert property (@(posedge clk_in) disable iff (srst_in || !ce_in)
		!mirrored |-> state != MME_WR_MIR && state != MME_RD_RETRY)
		else $error("mirror op while off");
	read_select_a: assert property (@(posedge clk_in) disable iff (srst_in || !ce_in)
		state == MME_IDLE && req_valid_in && req_ready_out && !req_write_in && mirrored
		|=> cur_mirror == ($past(req_addr_in[`MME_COPY_SEL_BIT]) ^ $past(polarity)))
		else $error("bad copy select");
	pol_reset_a: assert property (@(posedge clk_in) $past(srst_in) |-> polarity == 1'b0)
		else $error("polarity not reset");
	retry_other_a: assert property (@(posedge clk_in) disable iff (srst_in || !ce_in)
		state == MME_RD_WAIT && mem_ack_in && mem_ue_in && mirrored
		|=> state == MME_RD_RETRY && cur_mirror != $past(cur_mirror))
		else $error("retry not on other copy");
	fatal_both_a: assert property (@(posedge clk_in) disable iff (srst_in || !ce_in)
		rsp_fatal_out && mirrored |-> $past(state) == MME_RD_RETRY)
		else $error("fatal after one copy");
	feat_exclusive_a: assert property (@(posedge clk_in) disable iff (srst_in)
		feat != MME_FEAT_NONE |=> feat == $past(feat))
		else $error("feature changed");
	ue_event_a: assert property (@(posedge clk_in) disable iff (srst_in || !ce_in)
		mem_ack_in && mem_ue_in && !mem_write_out |=> ue_event_out)
		else $error("ue not raised");
	cov_mwrite_c: cover property (@(posedge clk_in) state == MME_WR_MIR && mem_ack_in);
	cov_retry_c: cover property (@(posedge clk_in) state == MME_RD_RETRY && mem_ack_in);
	cov_fatal_c: cover property (@(posedge clk_in) rsp_fatal_out);
endmodule // mme_mirror_engine

// *** mme_dimm_model.sv ***
`timescale 1ns/1ps
`include "mme_cfg.svh"
module mme_dimm_model (
	input wire logic clk_in,
	input wire logic valid_in,
	input wire logic write_in,
	input wire logic mirror_in,
	input wire logic [`MME_CHUNK_W-1:0] cha_in,
	input wire logic [`MME_CHUNK_W-1:0] chb_in,
	input wire logic [2:0] err_in,
	input wire logic [1:0] wait_in,
	output logic ack_out,
	output logic [`MME_CHUNK_W-1:0] cha_out,
	output logic [`MME_CHUNK_W-1:0] chb_out,
	output logic ce_out,
	output logic ue_out
);
	logic [2*`MME_CHUNK_W-1:0] store [2];
	logic [1:0] cnt;
	initial
	begin
		{ack_out, ce_out, ue_out, cnt} = '0;
		{cha_out, chb_out} = '0;
	end
	// plain always: the initial block above also writes these variables
	always @(posedge clk_in)
	begin
		ack_out <= 1'b0;
		ce_out <= 1'b0;
		ue_out <= 1'b0;
		// lanes toggle when idle so stale data never looks valid
		cha_out <= ~cha_out;
		chb_out <= ~chb_out;
		if (valid_in && !ack_out)
		begin
			cnt <= cnt + 2'h1;
			if (cnt == wait_in)
			begin
				cnt <= 2'h0;
				ack_out <= 1'b1;
				ce_out <= err_in[2] & !write_in;
				ue_out <= err_in[mirror_in] & !write_in;
				if (write_in)
					store[mirror_in] <= {cha_in, chb_in};
				else
					{cha_out, chb_out} <= store[mirror_in];
			end
		end
	end
endmodule // mme_dimm_model

// *** memory_mirroring_engine_tb.sv ***
`timescale 1ns/1ps
`include "mme_cfg.svh"
module memory_mirroring_engine_tb;
	localparam logic [63:0] EV = 64'h0123_4567_89ab_cdef;
	localparam logic [63:0] OD = 64'hfedc_ba98_7654_3210;
	logic clk_in, srst_in, mirror_en_in, spare_en_in, polarity_in, polarity_we_in;
	logic interleave_in, req_valid_in, req_write_in, mem_ack_in, mem_ce_in, mem_ue_in;
	logic [15:0] leak_period_in;
	logic [31:0] req_addr_in, bucket_out;
	logic [1:0] req_slot_in, mwait;
	logic [2:0] merr;
	logic [63:0] req_even_in, req_odd_in, mem_cha_in, mem_chb_in, mem_cha_out, mem_chb_out;
	logic [63:0] rsp_even_out, rsp_odd_out;
	logic [31:0] mem_addr_out;
	logic req_ready_out, mem_valid_out, mem_write_out, mem_mirror_out, rsp_valid_out;
	logic rsp_fatal_out, ce_event_out, ue_event_out, mirror_active_out, mv_q, first_mir, pol;
	logic ce_in;
	int miscompares = 0, n_compared = 0, n_ack = 0, n_ce = 0, n_ue = 0;
	mme_mirror_engine dut (.clk_in, .srst_in, .ce_in, .mirror_en_in, .spare_en_in,
		.polarity_in, .polarity_we_in, .leak_period_in, .interleave_in, .req_valid_in,
		.req_write_in, .req_addr_in, .req_slot_in, .req_even_in, .req_odd_in, .mem_ack_in,
		.mem_cha_in, .mem_chb_in, .mem_ce_in, .mem_ue_in, .req_ready_out, .mem_valid_out,
		.mem_write_out, .mem_mirror_out, .mem_addr_out, .mem_cha_out, .mem_chb_out,
		.rsp_valid_out, .rsp_even_out, .rsp_odd_out, .rsp_fatal_out, .ce_event_out,
		.ue_event_out, .mirror_active_out, .bucket_out);
	mme_dimm_model mdl (.clk_in, .valid_in(mem_valid_out), .write_in(mem_write_out),
		.mirror_in(mem_mirror_out), .cha_in(mem_cha_out), .chb_in(mem_chb_out),
		.err_in(merr), .wait_in(mwait), .ack_out(mem_ack_in), .cha_out(mem_cha_in),
		.chb_out(mem_chb_in), .ce_out(mem_ce_in), .ue_out(mem_ue_in));
	initial
	begin
		clk_in = 1'b0;
		forever #2.5 clk_in = ~clk_in;
	end
	always @(posedge clk_in)
	begin
		if (mem_valid_out && !mv_q)
			first_mir = mem_mirror_out;
		mv_q = mem_valid_out;
		n_ack += mem_ack_in;
		n_ce += ce_event_out;
		n_ue += ue_event_out;
	end
	task automatic stop_test;
		$display("compared %0d miscompares %0d", n_compared, miscompares);
		if (miscompares == 0 && n_compared > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [127:0] got, exp);
		n_compared++;
		if (got !== exp)
		begin
			miscompares++;
			$display("mismatch %s exp %h got %h", nm, exp, got);
		end
	endtask
	task automatic do_reset(input logic m, s);
		srst_in <= 1'b1;
		mirror_en_in <= m;
		spare_en_in <= s;
		pol = 1'b0;
		repeat (8) @(posedge clk_in);
		srst_in <= 1'b0;
		repeat (3) @(posedge clk_in);
	endtask
	task automatic xfer(input logic w, a15, il, input logic [2:0] e, input logic [127:0] d,
		input logic ft);
		int i = 0;
		@(posedge clk_in);
		{req_valid_in, req_write_in, interleave_in, merr} <= {1'b1, w, il, e};
		{req_even_in, req_odd_in} <= {EV, OD};
		req_addr_in <= {16'h0000, a15, 15'h0000};
		do @(posedge clk_in); while (req_ready_out !== 1'b1 && ++i < 50);
		req_valid_in <= 1'b0;
		do @(posedge clk_in); while ((w ? req_ready_out : rsp_valid_out) !== 1'b1 && ++i < 90);
		if (i >= 90)
		begin
			miscompares++;
			stop_test;
		end
		chk("mem addr", mem_addr_out, {16'h0000, a15, 15'h0000});
		if (!w)
		begin
			chk("rsp data", {rsp_even_out, rsp_odd_out}, d);
			chk("rsp fatal", rsp_fatal_out, ft);
			chk("read copy", first_mir, a15 ^ pol);
		end
	endtask
	task automatic sc_unmirrored;
		do_reset(1'b0, 1'b1);
		mirror_en_in <= 1'b1;
		n_ack = 0;
		xfer(1'b1, 1'b0, 1'b1, 3'h0, '0, 1'b0);
		chk("single write", n_ack, 1);
		chk("feature", mirror_active_out, 1'b0);
		xfer(1'b0, 1'b0, 1'b1, 3'h1, {EV, OD}, 1'b1);
	endtask
	task automatic sc_mirror_write;
		do_reset(1'b1, 1'b0);
		chk("feature", mirror_active_out, 1'b1);
		n_ack = 0;
		xfer(1'b1, 1'b0, 1'b1, 3'h0, '0, 1'b0);
		chk("write count", n_ack, 2);
		chk("primary", mdl.store[0], {EV, OD});
		chk("mirror", mdl.store[1], {OD, EV});
	endtask
	task automatic sc_read_paths;
		for (int k = 0; k < 8; k++)
		begin
			if (k == 4)
			begin
				@(posedge clk_in);
				{polarity_in, polarity_we_in} <= 2'b11;
				@(posedge clk_in);
				polarity_we_in <= 1'b0;
				pol = 1'b1;
			end
			// non-interleaved mirror copy keeps lanes as stored
			xfer(1'b0, k[0], k[1], 3'h0, ((k[0] ^ pol) && !k[1]) ? {OD, EV} : {EV, OD},
				1'b0);
		end
	endtask
	task automatic sc_errors;
		mwait <= 2'h3;
		// count only this scenario's error events
		n_ce = 0;
		n_ue = 0;
		xfer(1'b0, pol, 1'b1, 3'h1, {EV, OD}, 1'b0);
		xfer(1'b0, pol, 1'b1, 3'h3, {EV, OD}, 1'b1);
		xfer(1'b0, pol, 1'b1, 3'h4, {EV, OD}, 1'b0);
		repeat (3) @(posedge clk_in);
		chk("ue events", n_ue, 3);
		chk("ce events", n_ce, 1);
		chk("buckets", bucket_out, 32'h0000_0103);
		ce_in <= 1'b0;
		leak_period_in <= 16'h0004;
		repeat (20) @(posedge clk_in);
		chk("frozen", bucket_out, 32'h0000_0103);
		ce_in <= 1'b1;
		repeat (60) @(posedge clk_in);
		chk("leaked", bucket_out, 32'h0000_0000);
	endtask
	initial
	begin
		{srst_in, mirror_en_in, spare_en_in, polarity_in, polarity_we_in} = 5'b10000;
		ce_in = 1'b1;
		{interleave_in, req_valid_in, req_write_in, merr, mwait} = '0;
		{leak_period_in, req_addr_in, req_slot_in, req_even_in, req_odd_in} = '0;
		{mv_q, first_mir, pol} = '0;
		sc_unmirrored;
		sc_mirror_write;
		sc_read_paths;
		sc_errors;
		stop_test;
	end
endmodule // memory_mirroring_engine_tb
